// ===== hdl/plrs_top.sv
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "plrs_map.svh"

module plrs_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic undervoltage,
  input wire logic continue_operation_level,
  input wire logic low_energy,
  input wire logic supply_ok,
  input wire logic search_done,
  input wire plrs_pkg::plrs_freq_type search_freq,
  input wire plrs_pkg::plrs_freq_type ref_freq,
  output logic output_enable,
  output plrs_pkg::plrs_freq_type out_freq,
  output logic undervoltage_fault_code,
  output logic search_start
);
  import plrs_pkg::*;

  plrs_reg_if rif();

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [31:0] ctrl_r;
  logic [15:0] start_r;
  logic [31:0] gain_r;
  logic [`PLRS_ST_W-1:0] status_r;
  logic [`PLRS_ST_W-1:0] mask_r;
  logic [`PLRS_ST_W-1:0] ev;
  logic ack_r;
  logic [31:0] rdat_r;
  logic cmd_reset_r;
  logic cmd_run_r;
  plrs_state_type state_r;
  plrs_freq_type freq_r;

  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return res;
  endfunction

  wire req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wr = req && wb_we_i;
  wire rd = req && !wb_we_i;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_r <= `PLRS_CTRL_RST;
      start_r <= `PLRS_START_RST;
      gain_r <= `PLRS_GAIN_RST;
      mask_r <= '0;
    end else if (wr) begin
      if (wb_adr_i == `PLRS_OFS_CTRL) begin
        ctrl_r <= lane_merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_003F;
      end else if (wb_adr_i == `PLRS_OFS_START) begin
        start_r <= 16'(lane_merge({16'h0000, start_r}, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == `PLRS_OFS_GAIN) begin
        gain_r <= lane_merge(gain_r, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == `PLRS_OFS_MASK && wb_sel_i[0]) begin
        mask_r <= wb_dat_i[`PLRS_ST_W-1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cmd_reset_r <= 1'b0;
      cmd_run_r <= 1'b0;
    end else begin
      cmd_reset_r <= wr && wb_adr_i == `PLRS_OFS_CMD && wb_sel_i[0]
                     && wb_dat_i[`PLRS_CMD_RESET_BIT];
      cmd_run_r <= wr && wb_adr_i == `PLRS_OFS_CMD && wb_sel_i[0]
                   && wb_dat_i[`PLRS_CMD_RUN_BIT];
    end
  end

  // Set wins over read-clear so no event is lost
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      status_r <= '0;
    end else if (rd && wb_adr_i == `PLRS_OFS_STATUS) begin
      status_r <= ev;
    end else begin
      status_r <= status_r | ev;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdat_r <= '0;
    end else if (rd) begin
      if (wb_adr_i == `PLRS_OFS_CTRL) begin
        rdat_r <= ctrl_r;
      end else if (wb_adr_i == `PLRS_OFS_FREQ) begin
        rdat_r <= {16'h0000, freq_r};
      end else if (wb_adr_i == `PLRS_OFS_START) begin
        rdat_r <= {16'h0000, start_r};
      end else if (wb_adr_i == `PLRS_OFS_GAIN) begin
        rdat_r <= gain_r;
      end else if (wb_adr_i == `PLRS_OFS_STATUS) begin
        rdat_r <= {28'h000_0000, status_r};
      end else if (wb_adr_i == `PLRS_OFS_MASK) begin
        rdat_r <= {28'h000_0000, mask_r};
      end else if (wb_adr_i == `PLRS_OFS_STATE) begin
        rdat_r <= {29'h0000_0000, state_r};
      end else if (wb_adr_i == `PLRS_OFS_OUTF) begin
        rdat_r <= {16'h0000, out_freq};
      end else begin
        rdat_r <= '0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |((status_r | ev) & mask_r);
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  assign rif.mode = ctrl_r[`PLRS_CTRL_MODE_LSB +: 3];
  assign rif.torque_control_select = ctrl_r[`PLRS_CTRL_TORQ_BIT];
  assign rif.motor1_active = ctrl_r[`PLRS_CTRL_MOT1_BIT];
  assign rif.speed_search_select = ctrl_r[`PLRS_CTRL_SRCH_BIT];
  assign rif.starting_frequency_setting = start_r;
  assign rif.ride_through_integral_gain = gain_r[15:0];
  assign rif.ride_through_proportional_gain = gain_r[31:16];
  assign rif.cmd_reset = cmd_reset_r;
  assign rif.cmd_run = cmd_run_r;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic [2:0] mode_r;
  logic need_run_r;
  logic [15:0] dec_cnt_r;
  logic [15:0] step;
  logic uv_d_r;
  logic sup_d_r;

  wire uv_rise = undervoltage && !uv_d_r;
  wire sup_rise = supply_ok && !sup_d_r;
  wire dec_tick = dec_cnt_r == 16'(`PLRS_DEC_STEP_CYC - 1);
  wire regulating = state_r == PLRS_DECEL || state_r == PLRS_RIDE;

  // torque control with motor1 active folds two to five into one
  function automatic logic [2:0] eff_mode(input logic [2:0] m, input logic tq,
                                          input logic m1);
    logic [2:0] r;
    r = (m > `PLRS_MODE_MAX) ? 3'h0 : m;
    if (tq && m1 && r >= 3'h2) begin
      r = 3'h1;
    end
    return r;
  endfunction

  function automatic logic in_band(input logic [15:0] f);
    return f >= `PLRS_SRCH_LO && f <= `PLRS_SRCH_HI;
  endfunction

  plrs_ride_reg u_reg (
    .ref_clk(ref_clk),
    .reset(reset),
    .active(regulating),
    .bus_low(continue_operation_level),
    .ki(rif.ride_through_integral_gain),
    .kp(rif.ride_through_proportional_gain),
    .step(step)
  );

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      uv_d_r <= 1'b0;
      // Supply idles high, so no false recovery edge after reset
      sup_d_r <= 1'b1;
      dec_cnt_r <= '0;
    end else begin
      uv_d_r <= undervoltage;
      sup_d_r <= supply_ok;
      dec_cnt_r <= (dec_tick || !regulating && state_r != PLRS_ACCEL) ? '0 : dec_cnt_r + 1'b1;
    end
  end

  logic state_r_nxt_trip;
  logic search_start_nxt;
  logic restart_go;
  plrs_state_type state_nxt;
  plrs_freq_type freq_nxt;
  plrs_freq_type out_nxt;

  assign ev[`PLRS_ST_FAULT] = state_r != PLRS_TRIP && state_r_nxt_trip;
  assign ev[`PLRS_ST_UV] = uv_rise;
  assign ev[`PLRS_ST_RECOV] = sup_rise;
  assign ev[`PLRS_ST_RESTART] = search_start_nxt || restart_go;

  always_comb begin
    state_nxt = state_r;
    freq_nxt = freq_r;
    out_nxt = out_freq;
    search_start_nxt = 1'b0;
    restart_go = 1'b0;
    case (state_r)
      PLRS_IDLE: begin
        out_nxt = '0;
        if (rif.cmd_run && !undervoltage) begin
          state_nxt = PLRS_RUN;
        end
      end
      PLRS_RUN: begin
        out_nxt = ref_freq;
        if (undervoltage || continue_operation_level) begin
          freq_nxt = out_freq;
        end
        if (undervoltage) begin
          state_nxt = (eff_mode(rif.mode, rif.torque_control_select, rif.motor1_active)
                       == 3'h0) ? PLRS_TRIP : PLRS_COAST;
        end else if (continue_operation_level) begin
          if (eff_mode(rif.mode, rif.torque_control_select, rif.motor1_active) == 3'h2) begin
            state_nxt = PLRS_DECEL;
          end else if (eff_mode(rif.mode, rif.torque_control_select,
                                rif.motor1_active) == 3'h3) begin
            state_nxt = PLRS_RIDE;
          end
        end
      end
      PLRS_DECEL: begin
        if (low_energy || undervoltage || out_freq == '0) begin
          state_nxt = PLRS_TRIP;
          out_nxt = '0;
        end else if (dec_tick) begin
          out_nxt = (out_freq > step) ? out_freq - step : '0;
        end
      end
      PLRS_RIDE: begin
        if (undervoltage) begin
          state_nxt = PLRS_COAST;
          out_nxt = '0;
        end else if (!continue_operation_level) begin
          state_nxt = PLRS_ACCEL;
        end else if (dec_tick) begin
          out_nxt = (out_freq > step) ? out_freq - step : '0;
        end
      end
      PLRS_COAST: begin
        out_nxt = '0;
        if (supply_ok && !undervoltage) begin
          if (mode_r == 3'h0 || mode_r == 3'h1 || mode_r == 3'h2) begin
            state_nxt = PLRS_TRIP;
          end else if (rif.speed_search_select) begin
            state_nxt = PLRS_SEARCH;
            search_start_nxt = 1'b1;
          end else begin
            state_nxt = PLRS_ACCEL;
            restart_go = 1'b1;
            if (mode_r == 3'h5) begin
              freq_nxt = rif.starting_frequency_setting;
            end
            out_nxt = (mode_r == 3'h5) ? rif.starting_frequency_setting : freq_r;
          end
        end
      end
      PLRS_SEARCH: begin
        if (search_done) begin
          state_nxt = PLRS_ACCEL;
          restart_go = 1'b1;
          out_nxt = in_band(search_freq) ? search_freq : freq_r;
        end
      end
      PLRS_ACCEL: begin
        if (undervoltage) begin
          state_nxt = PLRS_COAST;
          out_nxt = '0;
        end else if (out_freq >= freq_r) begin
          state_nxt = PLRS_RUN;
        end else if (dec_tick) begin
          out_nxt = out_freq + 16'h0001;
        end
      end
      PLRS_TRIP: begin
        out_nxt = '0;
        if (rif.cmd_reset && !undervoltage) begin
          state_nxt = (mode_r == 3'h1) ? PLRS_RUN : PLRS_IDLE;
        end
      end
      default: begin
        state_nxt = PLRS_IDLE;
      end
    endcase
  end

  assign state_r_nxt_trip = state_nxt == PLRS_TRIP;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= PLRS_IDLE;
      out_freq <= '0;
      search_start <= 1'b0;
    end else begin
      state_r <= state_nxt;
      out_freq <= out_nxt;
      search_start <= search_start_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      freq_r <= '0;
    end else begin
      freq_r <= freq_nxt;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mode_r <= 3'h0;
    end else if (state_r == PLRS_RUN && (undervoltage || continue_operation_level)) begin
      mode_r <= eff_mode(rif.mode, rif.torque_control_select, rif.motor1_active);
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      output_enable <= 1'b0;
      undervoltage_fault_code <= 1'b0;
    end else begin
      output_enable <= state_nxt == PLRS_RUN || state_nxt == PLRS_DECEL
                       || state_nxt == PLRS_RIDE || state_nxt == PLRS_ACCEL;
      undervoltage_fault_code <= state_nxt == PLRS_TRIP;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_trip0;
    @(posedge ref_clk) disable iff (reset)
      state_r == PLRS_RUN && undervoltage
      && eff_mode(rif.mode, rif.torque_control_select, rif.motor1_active) == 3'h0
      |=> undervoltage_fault_code && !output_enable;
  endproperty
  a_trip0: assert property (p_trip0) else $error("mode zero did not trip");

  property p_coast1;
    @(posedge ref_clk) disable iff (reset)
      state_r == PLRS_RUN && undervoltage
      && eff_mode(rif.mode, rif.torque_control_select, rif.motor1_active) != 3'h0
      |=> !undervoltage_fault_code && !output_enable;
  endproperty
  a_coast1: assert property (p_coast1) else $error("stop raised fault");

  property p_norestart;
    @(posedge ref_clk) disable iff (reset)
      state_r == PLRS_TRIP && !rif.cmd_reset |=> !output_enable;
  endproperty
  a_norestart: assert property (p_norestart) else $error("restart without reset");

  property p_latch;
    @(posedge ref_clk) disable iff (reset)
      state_r == PLRS_COAST && $stable(state_r) |-> $stable(freq_r);
  endproperty
  a_latch: assert property (p_latch) else $error("latched frequency moved");

  property p_mode_hold;
    @(posedge ref_clk) disable iff (reset)
      state_r == PLRS_COAST ##1 state_r == PLRS_COAST |-> $stable(mode_r);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed");

  property p_start5;
    @(posedge ref_clk) disable iff (reset)
      state_r == PLRS_COAST && state_nxt == PLRS_ACCEL && mode_r == 3'h5
      |=> out_freq == rif.starting_frequency_setting;
  endproperty
  a_start5: assert property (p_start5) else $error("mode five frequency");

  property p_rec1;
    @(posedge ref_clk) disable iff (reset)
      state_r == PLRS_COAST && mode_r == 3'h1 && supply_ok && !undervoltage
      |=> undervoltage_fault_code;
  endproperty
  a_rec1: assert property (p_rec1) else $error("no trip at recovery");

  property p_band;
    @(posedge ref_clk) disable iff (reset)
      state_r == PLRS_SEARCH && search_done && !in_band(search_freq)
      |=> out_freq == freq_r;
  endproperty
  a_band: assert property (p_band) else $error("out of band search used");

endmodule

`default_nettype wire

// ===== hdl/plrs_map.svh
`ifndef PLRS_MAP_SVH
`define PLRS_MAP_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PLRS_OFS_CTRL 8'h00
`define PLRS_OFS_FREQ 8'h04
`define PLRS_OFS_START 8'h08
`define PLRS_OFS_GAIN 8'h0C
`define PLRS_OFS_STATUS 8'h10
`define PLRS_OFS_MASK 8'h14
`define PLRS_OFS_STATE 8'h18
`define PLRS_OFS_OUTF 8'h1C
`define PLRS_OFS_CMD 8'h20

// ----------------------------------------
// Control fields
// ----------------------------------------
`define PLRS_CTRL_MODE_LSB 0
`define PLRS_CTRL_TORQ_BIT 3
`define PLRS_CTRL_MOT1_BIT 4
`define PLRS_CTRL_SRCH_BIT 5
`define PLRS_CTRL_RST 32'h0000_0010

// ----------------------------------------
// Command bits (write of the command register)
// ----------------------------------------
`define PLRS_CMD_RESET_BIT 0
`define PLRS_CMD_RUN_BIT 1

// ----------------------------------------
// Status and interrupt bits
// ----------------------------------------
`define PLRS_ST_FAULT 0
`define PLRS_ST_UV 1
`define PLRS_ST_RECOV 2
`define PLRS_ST_RESTART 3
`define PLRS_ST_W 4

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define PLRS_START_RST 16'h0001
`define PLRS_GAIN_RST 32'h0001_0001
`define PLRS_MODE_MAX 3'h5
`define PLRS_SRCH_LO 16'h0005
`define PLRS_SRCH_HI 16'h0064
`define PLRS_CLK_MHZ 200
`define PLRS_DEC_STEP_NS 1000
`define PLRS_DEC_STEP_CYC ((`PLRS_DEC_STEP_NS * `PLRS_CLK_MHZ) / 1000)

`endif

// ===== hdl/plrs_pkg.sv
package plrs_pkg;

  typedef enum logic [2:0] {
    PLRS_IDLE,
    PLRS_RUN,
    PLRS_DECEL,
    PLRS_RIDE,
    PLRS_COAST,
    PLRS_TRIP,
    PLRS_SEARCH,
    PLRS_ACCEL
  } plrs_state_type;

  typedef logic [15:0] plrs_freq_type;

endpackage

// ===== hdl/plrs_reg_if.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Settings between register file and sequencer
// ----------------------------------------
interface plrs_reg_if;
  logic [2:0] mode;
  logic torque_control_select;
  logic motor1_active;
  logic speed_search_select;
  logic [15:0] starting_frequency_setting;
  logic [15:0] ride_through_integral_gain;
  logic [15:0] ride_through_proportional_gain;
  logic cmd_reset;
  logic cmd_run;

  modport regs (
    output mode, torque_control_select, motor1_active, speed_search_select,
    output starting_frequency_setting, ride_through_integral_gain,
    output ride_through_proportional_gain, cmd_reset, cmd_run
  );
  modport seq (
    input mode, torque_control_select, motor1_active, speed_search_select,
    input starting_frequency_setting, ride_through_integral_gain,
    input ride_through_proportional_gain, cmd_reset, cmd_run
  );
endinterface

`default_nettype wire

// ===== hdl/plrs_ride_reg.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Bus-level regulator for controlled stop and ride-through
// ----------------------------------------
module plrs_ride_reg (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic active,
  input wire logic bus_low,
  input wire logic [15:0] ki,
  input wire logic [15:0] kp,
  output logic [15:0] step
);
  import plrs_pkg::*;

  logic [15:0] integ_r;
  logic [15:0] integ_nxt;

  always_comb begin
    integ_nxt = integ_r;
    if (!active) begin
      integ_nxt = 16'h0000;
    end else if (bus_low && integ_r < 16'hFFFF - ki) begin
      integ_nxt = integ_r + ki;
    end else if (!bus_low && integ_r > ki) begin
      integ_nxt = integ_r - ki;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      integ_r <= 16'h0000;
    end else begin
      integ_r <= integ_nxt;
    end
  end

  // Low bus shrinks the step: slower braking returns less, keeps bus up
  always_comb begin
    step = 16'h0001;
    if (active && !bus_low) begin
      step = 16'h0001 + (kp >> 8) + (integ_r >> 8);
    end
  end

endmodule

`default_nettype wire

// ===== tb/plrs_supply_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Supply detector and speed pick-up
// ----------------------------------------
module plrs_supply_model #(
  parameter int SRCH_DLY = 20
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic dip,
  input wire logic search_start,
  input wire plrs_pkg::plrs_freq_type search_value,
  output logic undervoltage,
  output logic supply_ok,
  output logic search_done,
  output plrs_pkg::plrs_freq_type search_freq
);
  import plrs_pkg::*;
  int cnt_r;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      undervoltage <= 1'b0;
      supply_ok <= 1'b1;
    end else begin
      undervoltage <= dip;
      supply_ok <= !dip;
    end
  end

  // speed answer
  // The result frequency line shows garbage outside the answer cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 0;
      search_done <= 1'b0;
      search_freq <= 16'h0000;
    end else begin
      cnt_r <= search_start ? SRCH_DLY : (cnt_r > 0 ? cnt_r - 1 : 0);
      search_done <= (cnt_r == 1);
      search_freq <= (cnt_r == 1) ? search_value : ~search_freq;
    end
  end
endmodule

`default_nettype wire

// ===== tb/test_power_loss_restart_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "plrs_map.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end

module test_power_loss_restart_sequencer;
  import plrs_pkg::*;
  logic ref_clk = 0;
  logic reset = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] q;
  logic ack, irq, dip, col, uv, sok, sdone, ss, oe, fault;
  plrs_freq_type sfreq, outf;
  plrs_freq_type ref_freq = 16'h0014;
  plrs_freq_type sval = 16'h0028;
  int num_errors = 0;
  int checked = 0;

  initial dip = 0;
  initial col = 0;
  always #2.5 ref_clk = ~ref_clk;

  plrs_top u_plrs_top (.ref_clk(ref_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq(irq), .undervoltage(uv), .continue_operation_level(col),
    .low_energy(1'b0), .supply_ok(sok), .search_done(sdone), .search_freq(sfreq),
    .ref_freq(ref_freq), .output_enable(oe), .out_freq(outf),
    .undervoltage_fault_code(fault), .search_start(ss));

  plrs_supply_model u_plrs_supply_model (.ref_clk(ref_clk), .reset(reset), .dip(dip),
    .search_start(ss), .undervoltage(uv), .supply_ok(sok), .search_done(sdone),
    .search_freq(sfreq), .search_value(sval));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) num_errors++;
    q = rdat;
    cyc <= 0;
    stb <= 0;
  endtask

  // Bounded wait on oe (0), out_freq (1) or fault (2)
  task automatic wt(input int k, input logic [15:0] v);
    logic [15:0] s;
    for (int i = 0; i < 6000; i++) begin
      @(negedge ref_clk);
      s = (k == 0) ? {15'h0, oe} : (k == 1) ? outf : {15'h0, fault};
      if (s === v) break;
    end
    if (s !== v) num_errors++;
  endtask

  task automatic power_dip(input logic v);
    dip <= v;
    repeat (4) @(negedge ref_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    bus(0, `PLRS_OFS_CTRL, 0);
    `CHK("ctrl", `PLRS_CTRL_RST, q)
    bus(0, `PLRS_OFS_START, 0);
    `CHK("start", 32'h0000_0001, q)
    bus(0, `PLRS_OFS_GAIN, 0);
    `CHK("gain", `PLRS_GAIN_RST, q)
    bus(0, 8'h3C, 0);
    `CHK("unmapped", 32'h0000_0000, q)
  endtask

  task automatic t_mode0;
    bus(1, `PLRS_OFS_CTRL, 32'h0000_0000);
    bus(1, `PLRS_OFS_MASK, 32'h0000_0001);
    bus(1, `PLRS_OFS_CMD, 32'h0000_0002);
    wt(0, 1);
    power_dip(1);
    `CHK("m0 oe", 1'b0, oe)
    `CHK("m0 fault", 1'b1, fault)
    `CHK("m0 irq", 1'b1, irq)
    bus(0, `PLRS_OFS_STATUS, 0);
    `CHK("m0 st", 1'b1, q[`PLRS_ST_FAULT])
    @(negedge ref_clk);
    `CHK("m0 irq clr", 1'b0, irq)
    power_dip(0);
    repeat (50) @(negedge ref_clk);
    `CHK("m0 no restart", 1'b0, oe)
    bus(1, `PLRS_OFS_CMD, 32'h0000_0001);
    bus(1, `PLRS_OFS_CMD, 32'h0000_0002);
    wt(0, 1);
    `CHK("m0 resume", 1'b1, oe)
  endtask

  task automatic t_mode1(input logic [31:0] ctrl);
    bus(1, `PLRS_OFS_CTRL, ctrl);
    power_dip(1);
    `CHK("m1 oe", 1'b0, oe)
    `CHK("m1 no fault", 1'b0, fault)
    power_dip(0);
    `CHK("m1 fault", 1'b1, fault)
    bus(1, `PLRS_OFS_CMD, 32'h0000_0001);
    wt(0, 1);
    `CHK("m1 resume", 1'b1, oe)
  endtask

  // Latched value must survive a new mode and a new reference frequency
  task automatic t_mode4;
    bus(1, `PLRS_OFS_CTRL, 32'h0000_0004);
    wt(1, 16'h0014);
    power_dip(1);
    @(posedge ref_clk);
    ref_freq <= 16'h001E;
    bus(1, `PLRS_OFS_CTRL, 32'h0000_0000);
    `CHK("m4 oe", 1'b0, oe)
    `CHK("m4 no trip", 1'b0, fault)
    bus(0, `PLRS_OFS_FREQ, 0);
    `CHK("m4 latch", 32'h0000_0014, q)
    dip <= 0;
    wt(0, 1);
    `CHK("m4 freq", 16'h0014, outf)
    `CHK("m4 held mode", 1'b0, fault)
  endtask

  task automatic t_mode5_search;
    bus(1, `PLRS_OFS_START, 32'h0000_0007);
    bus(1, `PLRS_OFS_CTRL, 32'h0000_0005);
    power_dip(1);
    dip <= 0;
    wt(0, 1);
    `CHK("m5 freq", 16'h0007, outf)
    bus(1, `PLRS_OFS_CTRL, 32'h0000_0024);
    power_dip(1);
    power_dip(0);
    wt(1, 16'h0028);
    `CHK("search freq", 16'h0028, outf)
    wt(1, 16'h001E);
    sval <= 16'h0200;
    power_dip(1);
    dip <= 0;
    wt(0, 1);
    `CHK("band fallback", 16'h001E, outf)
  endtask

  // Recovery inside ride-through climbs back to the latched frequency
  task automatic t_mode3;
    @(posedge ref_clk);
    ref_freq <= 16'h000A;
    bus(1, `PLRS_OFS_CTRL, 32'h0000_0003);
    wt(1, 16'h000A);
    @(posedge ref_clk);
    col <= 1;
    repeat (450) @(negedge ref_clk);
    `CHK("m3 ride", 16'h0008, outf)
    @(posedge ref_clk);
    col <= 0;
    wt(1, 16'h000A);
    `CHK("m3 back", 16'h000A, outf)
    `CHK("m3 oe", 1'b1, oe)
  endtask

  task automatic t_mode2;
    ref_freq <= 16'h000A;
    bus(1, `PLRS_OFS_CTRL, 32'h0000_0002);
    wt(1, 16'h000A);
    @(posedge ref_clk);
    col <= 1;
    wt(2, 1);
    @(posedge ref_clk);
    col <= 0;
    `CHK("m2 stopped", 16'h0000, outf)
    `CHK("m2 fault", 1'b1, fault)
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #200000;
    num_errors++;
    finish_test;
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 0;
    t_regs;
    t_mode0;
    t_mode1(32'h0000_0001);
    t_mode4;
    t_mode5_search;
    t_mode1(32'h0000_001A);
    t_mode3;
    t_mode2;
    finish_test;
  end
endmodule

`default_nettype wire
